// *** shared/mdh_map.vh ***
// register offsets, field positions and timing constants of the modem control register set
// assumes mclk at 200 MHz; included by mdh_regs, the host model and the bench
`ifndef MDH_MAP_VH
`define MDH_MAP_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define MDH_OFF_CONFIG 4'h0
`define MDH_OFF_DIAL 4'h4
`define MDH_OFF_HANDSHAKE 4'h8
`define MDH_OFF_STATUS 4'hC
// test register lives in a second word bank
`define MDH_OFF_TEST 5'h10
`define MDH_ADDR_W 5
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define MDH_CFG_STD 1
`define MDH_CFG_GUARD_SEL 6
`define MDH_DIAL_TONE_EN 4
`define MDH_DIAL_CPT_EN 5
`define MDH_DIAL_MUTE 6
`define MDH_DIAL_HOOK 7
`define MDH_HC_TX_EN 0
`define MDH_HC_SCR_EN 1
`define MDH_HC_GUARD_EN 2
`define MDH_HC_ANS_EN 3
`define MDH_HC_MON_EN 4
`define MDH_HC_AUX_EN 5
`define MDH_HC_ORIG 6
`define MDH_HC_DOT_EN 7
`define MDH_TM_PWR_UP 0
`define MDH_TM_ALOOP 1
`define MDH_TM_DLOOP 2
`define MDH_RST_BYTE 8'h00
// -----------------------------------------------------------------
// timing: persistence counts in mclk cycles at 200 MHz
// -----------------------------------------------------------------
// 160 ms
`define MDH_CYC_SHORT 26'h1E84800
// 267 ms
`define MDH_CYC_LONG 26'h32ED1C0
// carrier on and off persistence
`define MDH_CYC_CARRIER 26'h0000100
`define MDH_CNT_W 26
// axi answers
`define MDH_RESP_OKAY 2'h0
`define MDH_RESP_SLVERR 2'h2
`endif

// *** rtl/mdh_persist.v ***
// persistence timer: flags a condition held without break for a set number of cycles
// assumes one clock, synchronous active-high reset
`timescale 1ns/100ps
module mdh_persist #(
	parameter [25:0] LIMIT = 26'h0000010
) (
	input wire mclk,
	input wire sys_rst,
	input wire cond,
	output reg hit
);
	reg [25:0] cnt_q;
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			cnt_q <= 26'h0000000;
			hit <= 1'b0;
		end
		else if (!cond)
		begin
			cnt_q <= 26'h0000000;
			hit <= 1'b0;
		end
		else if (cnt_q != LIMIT)
		begin
			cnt_q <= cnt_q + 26'h0000001;
			hit <= 1'b0;
		end
		else
			hit <= 1'b1;
	end
endmodule // mdh_persist

// *** rtl/mdh_regs.v ***
// control and status registers of a low-speed modem: dialing, handshake, test and power
// assumes AXI4-Lite master on mclk, analog/detector front end reporting raw conditions
//
// Operation
// R01: tone enable drives dialer with low digit
// R02: progress detector enable reports tones on carrier
// R03: host clears progress enable after ringback
// R04: mute bit mutes receive buffer amplifier
// R05: hook bit drives hook switch output
// R06: host times pulse dialing via hook
// R07: tx enable, else line held common-mode
// R08: scrambler enable inserts scrambler in path
// R09: guard tone enable, carrier dropped 1dB
// R10: answer tone 2225 or 2100 Hz
// R11: monitor output enable; aux input to line
// R12: originate low-band tx, answer high-band
// R13: dotting pattern needs scrambler also set
// R14: status rising edges raise interrupt
// R15: speed bit, cleared when carrier falls
// R16: answer/low mark over 160ms set bits
// R17: scrambled mark 267ms sets bit 2
// R18: dotting pattern 267ms sets bit 4
// R19: status read clears bits 1..4
// R20: power-up bit zero powers device down
// R21: analog and digital loopback enables
// R22: guard tone select 1800 or 550 Hz
// R23: config selects first standard or second
// R24: carrier flag follows detector thresholds
// R25: control bits clear on reset
`timescale 1ns/100ps
`include "mdh_map.vh"
module mdh_regs (
	input wire mclk,
	input wire sys_rst,
	// axi4-lite slave
	input wire [`MDH_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`MDH_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// front-end raw conditions
	input wire sig_above_thresh,
	input wire rx_speed_300,
	input wire handshaking,
	input wire ans_tone_2225_det,
	input wire high_unscr_mark_det,
	input wire low_unscr_mark_det,
	input wire scr_mark_det,
	input wire dotting_det,
	input wire modem_stat_irq_en,
	// front-end controls
	output reg tone_gen_en,
	output reg [3:0] dial_digit,
	output reg progress_det_en,
	output reg carrier_present,
	output reg rx_mute,
	output reg hook_switch_out,
	output reg line_tx_en,
	output reg scrambler_en,
	output reg guard_tone_en,
	output reg guard_tone_550,
	output reg carrier_minus_1db,
	output reg answer_tone_en,
	output reg answer_tone_2100,
	output reg audio_monitor_en,
	output reg aux_audio_en,
	output reg originate_answer_select,
	output reg dotting_en,
	output reg analog_out_tristate,
	output reg analog_loop_en,
	output reg digital_loop_en,
	output reg irq_out
);
	// -----------------------------------------------------------------
	// constants and state
	// -----------------------------------------------------------------
	localparam [25:0] CYC_SHORT = `MDH_CYC_SHORT;
	localparam [25:0] CYC_LONG = `MDH_CYC_LONG;
	localparam [25:0] CYC_CARRIER = `MDH_CYC_CARRIER;
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RESP = 2'h1;
	reg [7:0] config_q;
	reg [7:0] dial_q;
	reg [7:0] hsc_q;
	reg [7:0] test_q;
	reg [4:0] stat_q;
	reg [4:0] stat_prev_q;
	reg carrier_prev_q;
	reg [1:0] wst_q;
	reg [1:0] rst_st_q;
	reg aw_have_q;
	reg w_have_q;
	reg [`MDH_ADDR_W-1:0] awaddr_q;
	reg [7:0] wbyte_q;
	reg wlane_q;
	wire carrier_on_hit;
	wire carrier_off_hit;
	wire ans_hit;
	wire low_hit;
	wire scr_hit;
	wire dot_hit;
	wire [4:0] stat_set;
	wire stat_read;
	wire powered;
	wire v22;
	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function known_addr;
		input [`MDH_ADDR_W-1:0] a;
		begin
			known_addr = (a == {1'b0, `MDH_OFF_CONFIG}) || (a == {1'b0, `MDH_OFF_DIAL})
				|| (a == {1'b0, `MDH_OFF_HANDSHAKE}) || (a == {1'b0, `MDH_OFF_STATUS})
				|| (a == `MDH_OFF_TEST);
		end
	endfunction
	// -----------------------------------------------------------------
	// detector persistence
	// -----------------------------------------------------------------
	mdh_persist #(.LIMIT(CYC_CARRIER)) u_carrier_on (.mclk(mclk), .sys_rst(sys_rst),
		.cond(sig_above_thresh), .hit(carrier_on_hit));
	mdh_persist #(.LIMIT(CYC_CARRIER)) u_carrier_off (.mclk(mclk), .sys_rst(sys_rst),
		.cond(!sig_above_thresh), .hit(carrier_off_hit));
	mdh_persist #(.LIMIT(CYC_SHORT)) u_ans (.mclk(mclk), .sys_rst(sys_rst),
		.cond(handshaking && (ans_tone_2225_det || high_unscr_mark_det)), .hit(ans_hit)); // R16
	mdh_persist #(.LIMIT(CYC_SHORT)) u_low (.mclk(mclk), .sys_rst(sys_rst),
		.cond(low_unscr_mark_det), .hit(low_hit)); // R16
	mdh_persist #(.LIMIT(CYC_LONG)) u_scr (.mclk(mclk), .sys_rst(sys_rst),
		.cond(scr_mark_det), .hit(scr_hit)); // R17
	mdh_persist #(.LIMIT(CYC_LONG)) u_dot (.mclk(mclk), .sys_rst(sys_rst),
		.cond(dotting_det), .hit(dot_hit)); // R18
	assign powered = test_q[`MDH_TM_PWR_UP];
	assign v22 = config_q[`MDH_CFG_STD];
	assign stat_set = {dot_hit, low_hit, scr_hit, ans_hit, 1'b0};
	assign stat_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == {1'b0, `MDH_OFF_STATUS});
	// -----------------------------------------------------------------
	// write channel
	// -----------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			config_q <= `MDH_RST_BYTE;
			dial_q <= `MDH_RST_BYTE; // R25
			hsc_q <= `MDH_RST_BYTE; // R25
			test_q <= `MDH_RST_BYTE; // R25
			wst_q <= ST_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= {`MDH_ADDR_W{1'b0}};
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MDH_RESP_OKAY;
		end
		else
		begin
			case (wst_q)
				ST_IDLE:
				begin
					s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
					s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
					if (s_axi_awvalid && s_axi_awready)
					begin
						aw_have_q <= 1'b1;
						awaddr_q <= s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready)
					begin
						w_have_q <= 1'b1;
						wbyte_q <= s_axi_wdata[7:0];
						wlane_q <= s_axi_wstrb[0];
					end
					if (aw_have_q && w_have_q)
					begin
						s_axi_awready <= 1'b0;
						s_axi_wready <= 1'b0;
						aw_have_q <= 1'b0;
						w_have_q <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= known_addr(awaddr_q) ? `MDH_RESP_OKAY : `MDH_RESP_SLVERR;
						wst_q <= ST_RESP;
						if (wlane_q)
						begin
							if (awaddr_q == {1'b0, `MDH_OFF_CONFIG})
								config_q <= wbyte_q;
							if (awaddr_q == {1'b0, `MDH_OFF_DIAL})
								dial_q <= wbyte_q;
							if (awaddr_q == {1'b0, `MDH_OFF_HANDSHAKE})
								hsc_q <= wbyte_q;
							if (awaddr_q == `MDH_OFF_TEST)
								test_q <= {5'h00, wbyte_q[2:0]}; // R21
						end
					end
				end
				ST_RESP:
				begin
					if (s_axi_bready)
					begin
						s_axi_bvalid <= 1'b0;
						wst_q <= ST_IDLE;
					end
				end
				default:
					wst_q <= ST_IDLE;
			endcase
		end
	end
	// -----------------------------------------------------------------
	// read channel, status capture and interrupt
	// -----------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rst_st_q <= ST_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `MDH_RESP_OKAY;
			stat_q <= 5'h00;
			stat_prev_q <= 5'h00;
			carrier_present <= 1'b0;
			carrier_prev_q <= 1'b0;
			irq_out <= 1'b0;
		end
		else
		begin
			stat_prev_q <= stat_q;
			carrier_prev_q <= carrier_present;
			if (carrier_on_hit)
				carrier_present <= 1'b1; // R24 R02
			else if (carrier_off_hit)
				carrier_present <= 1'b0; // R24
			// set wins over read clear
			stat_q[4:1] <= (stat_read ? 4'h0 : stat_q[4:1]) | stat_set[4:1]; // R19 R16 R17 R18
			if (carrier_prev_q && !carrier_present)
				stat_q[0] <= 1'b0; // R15
			else if (!v22 && !hsc_q[`MDH_HC_ORIG] && carrier_present)
				stat_q[0] <= rx_speed_300; // R15
			if (modem_stat_irq_en && |(stat_q & ~stat_prev_q))
				irq_out <= 1'b1; // R14
			else if (stat_read)
				irq_out <= 1'b0; // R14
			case (rst_st_q)
				ST_IDLE:
				begin
					s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
					if (s_axi_arvalid && s_axi_arready)
					begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= known_addr(s_axi_araddr) ? `MDH_RESP_OKAY : `MDH_RESP_SLVERR;
						case (s_axi_araddr)
							{1'b0, `MDH_OFF_CONFIG}: s_axi_rdata <= {24'h000000, config_q};
							{1'b0, `MDH_OFF_DIAL}: s_axi_rdata <= {24'h000000, dial_q};
							// handshake control is write only
							{1'b0, `MDH_OFF_STATUS}: s_axi_rdata <= {27'h0000000, stat_q}; // R19
							`MDH_OFF_TEST: s_axi_rdata <= {24'h000000, test_q};
							default: s_axi_rdata <= 32'h00000000;
						endcase
						rst_st_q <= ST_RESP;
					end
				end
				ST_RESP:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						rst_st_q <= ST_IDLE;
					end
				end
				default:
					rst_st_q <= ST_IDLE;
			endcase
		end
	end
	// -----------------------------------------------------------------
	// front-end controls
	// -----------------------------------------------------------------
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			tone_gen_en <= 1'b0;
			dial_digit <= 4'h0;
			progress_det_en <= 1'b0;
			rx_mute <= 1'b0;
			hook_switch_out <= 1'b0;
			line_tx_en <= 1'b0;
			scrambler_en <= 1'b0;
			guard_tone_en <= 1'b0;
			guard_tone_550 <= 1'b0;
			carrier_minus_1db <= 1'b0;
			answer_tone_en <= 1'b0;
			answer_tone_2100 <= 1'b0;
			audio_monitor_en <= 1'b0;
			aux_audio_en <= 1'b0;
			originate_answer_select <= 1'b0;
			dotting_en <= 1'b0;
			analog_out_tristate <= 1'b1;
			analog_loop_en <= 1'b0;
			digital_loop_en <= 1'b0;
		end
		else
		begin
			tone_gen_en <= powered && dial_q[`MDH_DIAL_TONE_EN]; // R01
			dial_digit <= dial_q[3:0]; // R01
			progress_det_en <= dial_q[`MDH_DIAL_CPT_EN]; // R02 R03
			rx_mute <= dial_q[`MDH_DIAL_MUTE]; // R04
			hook_switch_out <= powered && dial_q[`MDH_DIAL_HOOK]; // R05 R06 R20
			line_tx_en <= powered && hsc_q[`MDH_HC_TX_EN]; // R07
			scrambler_en <= hsc_q[`MDH_HC_SCR_EN]; // R08 R13
			guard_tone_en <= v22 && hsc_q[`MDH_HC_GUARD_EN]; // R09 R22
			guard_tone_550 <= config_q[`MDH_CFG_GUARD_SEL]; // R22
			carrier_minus_1db <= v22 && hsc_q[`MDH_HC_GUARD_EN]; // R09
			answer_tone_en <= hsc_q[`MDH_HC_ANS_EN]; // R10
			answer_tone_2100 <= v22; // R10 R23
			audio_monitor_en <= powered && hsc_q[`MDH_HC_MON_EN]; // R11
			aux_audio_en <= hsc_q[`MDH_HC_AUX_EN]; // R11
			originate_answer_select <= hsc_q[`MDH_HC_ORIG]; // R12
			dotting_en <= hsc_q[`MDH_HC_DOT_EN] && hsc_q[`MDH_HC_SCR_EN]; // R13
			analog_out_tristate <= !powered; // R20
			analog_loop_en <= test_q[`MDH_TM_ALOOP]; // R21
			digital_loop_en <= test_q[`MDH_TM_DLOOP]; // R21
		end
	end
endmodule // mdh_regs

// *** sim/mdh_regs_sva.sv ***
// checker for the modem control register set
// bound to mdh_regs, sees its ports only
`timescale 1ns/100ps
module mdh_regs_chk (
	input wire mclk,
	input wire sys_rst,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire sig_above_thresh,
	input wire carrier_present,
	input wire irq_out,
	input wire hook_switch_out,
	input wire line_tx_en,
	input wire analog_out_tristate,
	input wire scrambler_en,
	input wire dotting_en,
	input wire guard_tone_en,
	input wire carrier_minus_1db
);
default clocking cb @(posedge mclk); endclocking
default disable iff (sys_rst);
// cycles the receive level has stayed high
reg [9:0] hi_cnt_q;
always @(posedge mclk)
begin
	if (sys_rst || !sig_above_thresh)
		hi_cnt_q <= 10'h000;
	else if (hi_cnt_q != 10'h3FF)
		hi_cnt_q <= hi_cnt_q + 10'h001;
end
a_reset_out: assert property ($fell(sys_rst) |-> analog_out_tristate &&
	!hook_switch_out && !line_tx_en && !irq_out && !carrier_present)
	else $error("outputs not at reset value");
a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read answer late");
a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
	s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
	s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
a_dot_scr: assert property (dotting_en |-> scrambler_en)
	else $error("dotting without scrambler");
a_guard_1db: assert property (guard_tone_en |-> carrier_minus_1db)
	else $error("guard tone without carrier cut");
a_pwr_gate: assert property ((hook_switch_out || line_tx_en) |-> !analog_out_tristate)
	else $error("output active in power-down");
a_carrier_on: assert property ($rose(carrier_present) |->
	hi_cnt_q >= 10'h0FA && hi_cnt_q <= 10'h10E) else $error("carrier persistence wrong");
cover property ($rose(irq_out));
cover property ($rose(carrier_present));
cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // mdh_regs_chk

bind mdh_regs mdh_regs_chk u_chk (.*);

// *** sim/mdh_host_model.sv ***
// host model: AXI4-Lite master doing single register accesses
// assumes tasks are called after reset, one access at a time
`timescale 1ns/100ps
`include "mdh_map.vh"
module mdh_host_model (
	input wire mclk,
	output reg [`MDH_ADDR_W-1:0] s_axi_awaddr,
	output reg s_axi_awvalid,
	input wire s_axi_awready,
	output reg [31:0] s_axi_wdata,
	output reg [3:0] s_axi_wstrb,
	output reg s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	output reg s_axi_bready,
	output reg [`MDH_ADDR_W-1:0] s_axi_araddr,
	output reg s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	output reg s_axi_rready
);
initial
begin
	{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
	{s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 14'h0000;
	s_axi_wdata = 32'h00000000;
end
task wr(input [`MDH_ADDR_W-1:0] a, input [7:0] d, input [3:0] s, output [1:0] r);
	begin
	@(posedge mclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= {24'h000000, d};
	s_axi_wstrb <= s;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do
	begin
		@(posedge mclk);
		if (s_axi_awvalid && s_axi_awready)
			s_axi_awvalid <= 1'b0;
		if (s_axi_wvalid && s_axi_wready)
			s_axi_wvalid <= 1'b0;
	end
	while (s_axi_bvalid !== 1'b1);
	r = s_axi_bresp;
	s_axi_bready <= 1'b0;
	s_axi_wdata <= ~s_axi_wdata;
	end
endtask
task rd(input [`MDH_ADDR_W-1:0] a, output [31:0] d, output [1:0] r);
	begin
	@(posedge mclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do
	begin
		@(posedge mclk);
		if (s_axi_arvalid && s_axi_arready)
			s_axi_arvalid <= 1'b0;
	end
	while (s_axi_rvalid !== 1'b1);
	d = s_axi_rdata;
	r = s_axi_rresp;
	s_axi_rready <= 1'b0;
	s_axi_araddr <= ~s_axi_araddr;
	end
endtask
// power up, unused test bits written as zero
task power_up;
	logic [1:0] r;
	begin
	wr(`MDH_OFF_TEST, 8'h01, 4'hF, r);
	end
endtask
endmodule // mdh_host_model

// *** sim/test_modem_dial_handshake_regs.sv ***
// self-checking bench for the modem control register set
// assumes mdh_regs, the host model and the bound checker
`timescale 1ns/100ps
`include "mdh_map.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
$display("Error %s exp %0h got %0h", n, e, s); end end
module test_modem_dial_handshake_regs;
logic mclk, sys_rst;
logic [`MDH_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb, dial_digit;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic sig_above_thresh, rx_speed_300, handshaking, ans_tone_2225_det, high_unscr_mark_det;
logic low_unscr_mark_det, scr_mark_det, dotting_det, modem_stat_irq_en;
logic tone_gen_en, progress_det_en, carrier_present, rx_mute, hook_switch_out, line_tx_en;
logic scrambler_en, guard_tone_en, guard_tone_550, carrier_minus_1db, answer_tone_en;
logic answer_tone_2100, audio_monitor_en, aux_audio_en, originate_answer_select, dotting_en;
logic analog_out_tristate, analog_loop_en, digital_loop_en, irq_out;
int err_total, num_checks, n;
mdh_regs DUT (.*);
mdh_host_model u_host (.*);
initial
begin
	mclk = 1'b0;
	forever #2.5 mclk = ~mclk;
end
task results;
	begin
	$display("checks %0d errors %0d", num_checks, err_total);
	if (err_total == 0 && num_checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
	end
endtask
task wrc(input [4:0] a, input [7:0] d);
	logic [1:0] r;
	begin
	u_host.wr(a, d, 4'hF, r);
	`CHK("bresp", 2'h0, r)
	#1;
	end
endtask
task rdc(input [4:0] a, input [31:0] e, input [1:0] er);
	logic [31:0] d;
	logic [1:0] r;
	begin
	u_host.rd(a, d, r);
	`CHK("rresp", er, r)
	`CHK("rdata", e, d)
	end
endtask
task t_reset;
	begin
	`CHK("tri", 1'b1, analog_out_tristate)
	rdc(`MDH_OFF_DIAL, 32'h0, 2'h0);
	rdc(`MDH_OFF_TEST, 32'h0, 2'h0);
	end
endtask
task t_dial;
	begin
	u_host.power_up();
	wrc(`MDH_OFF_DIAL, 8'hF5);
	`CHK("dial", 8'hF5, {hook_switch_out, rx_mute, progress_det_en, tone_gen_en, dial_digit})
	wrc(`MDH_OFF_TEST, 8'h00);
	`CHK("hook_pd", 1'b0, hook_switch_out)
	rdc(`MDH_OFF_DIAL, 32'hF5, 2'h0);
	u_host.power_up();
	wrc(`MDH_OFF_DIAL, 8'h05);
	`CHK("hook_break", 1'b0, hook_switch_out)
	wrc(`MDH_OFF_DIAL, 8'h85);
	`CHK("dial2", 3'h4, {hook_switch_out, progress_det_en, tone_gen_en})
	end
endtask
task t_hsc;
	begin
	wrc(`MDH_OFF_CONFIG, 8'h42);
	wrc(`MDH_OFF_HANDSHAKE, 8'hFF);
	`CHK("tx", 4'hF, {line_tx_en, scrambler_en, guard_tone_en, carrier_minus_1db})
	`CHK("ans", 3'h7, {answer_tone_en, answer_tone_2100, guard_tone_550})
	`CHK("aud", 4'hF, {audio_monitor_en, aux_audio_en, originate_answer_select, dotting_en})
	rdc(`MDH_OFF_HANDSHAKE, 32'h0, 2'h0);
	wrc(`MDH_OFF_CONFIG, 8'h00);
	wrc(`MDH_OFF_HANDSHAKE, 8'h8D);
	`CHK("std1", 4'h8, {answer_tone_en, answer_tone_2100, guard_tone_en, guard_tone_550})
	`CHK("dot", 3'h0, {dotting_en, scrambler_en, originate_answer_select})
	end
endtask
task t_test;
	begin
	wrc(`MDH_OFF_TEST, 8'hFF);
	rdc(`MDH_OFF_TEST, 32'h07, 2'h0);
	`CHK("loop", 3'h6, {analog_loop_en, digital_loop_en, analog_out_tristate})
	u_host.power_up();
	#1;
	`CHK("loop0", 2'h0, {analog_loop_en, digital_loop_en})
	end
endtask
task t_carrier;
	begin
	wrc(`MDH_OFF_HANDSHAKE, 8'h01);
	@(posedge mclk);
	{handshaking, ans_tone_2225_det, high_unscr_mark_det, low_unscr_mark_det} <= 4'hF;
	{scr_mark_det, dotting_det, modem_stat_irq_en, rx_speed_300, sig_above_thresh} <= 5'h1F;
	for (n = 0; carrier_present !== 1'b1 && n < 400; n++)
		@(posedge mclk);
	`CHK("carrier_on", 1'b1, n >= 256 && n <= 264)
	for (n = 0; irq_out !== 1'b1 && n < 20; n++)
		@(posedge mclk);
	`CHK("irq", 1'b1, irq_out)
	rdc(`MDH_OFF_STATUS, 32'h01, 2'h0);
	repeat (2) @(posedge mclk);
	`CHK("irq_clr", 1'b0, irq_out)
	{handshaking, ans_tone_2225_det, high_unscr_mark_det, low_unscr_mark_det} <= 4'h0;
	{scr_mark_det, dotting_det, sig_above_thresh} <= 3'h0;
	for (n = 0; carrier_present !== 1'b0 && n < 400; n++)
		@(posedge mclk);
	`CHK("carrier_off", 1'b0, carrier_present)
	rdc(`MDH_OFF_STATUS, 32'h00, 2'h0);
	end
endtask
task t_err;
	logic [1:0] r;
	begin
	u_host.wr(5'h14, 8'hAA, 4'hF, r);
	`CHK("bresp_un", 2'h2, r)
	rdc(5'h14, 32'h0, 2'h2);
	u_host.wr(`MDH_OFF_DIAL, 8'h00, 4'h0, r);
	`CHK("bresp_st", 2'h0, r)
	rdc(`MDH_OFF_DIAL, 32'h85, 2'h0);
	end
endtask
initial
begin
	sys_rst = 1'b1;
	{sig_above_thresh, rx_speed_300, handshaking, ans_tone_2225_det} = 4'h0;
	{high_unscr_mark_det, low_unscr_mark_det, scr_mark_det, dotting_det} = 4'h0;
	modem_stat_irq_en = 1'b0;
	err_total = 0;
	num_checks = 0;
	repeat (12) @(posedge mclk);
	sys_rst <= 1'b0;
	@(posedge mclk);
	#1;
	t_reset;
	t_dial;
	t_hsc;
	t_test;
	t_carrier;
	t_err;
	results;
end
initial
begin
	repeat (20000) @(posedge mclk);
	err_total++;
	results;
end
endmodule // test_modem_dial_handshake_regs
